// ===== rtl/sclh_map.vh
// register offsets, field positions, reset values and character codes of the serial line handler
`ifndef SCLH_MAP_VH
`define SCLH_MAP_VH
// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SCLH_CTRL_OFS     12'h000
`define SCLH_STAT_OFS     12'h004
`define SCLH_LINE_OFS     12'h008
`define SCLH_LDATA_OFS    12'h00c
`define SCLH_LPOP_OFS     12'h010
`define SCLH_DONE_OFS     12'h014
// ****************************************************************
// control field positions and reset value
// ****************************************************************
`define SCLH_CTRL_BAUD_LO 0
`define SCLH_CTRL_BAUD_HI 1
`define SCLH_CTRL_ECHO    2
`define SCLH_CTRL_PROMPT  3
`define SCLH_CTRL_XON     4
`define SCLH_CTRL_LOOPRUN 5
`define SCLH_CTRL_RST     32'h0000_0005
// ****************************************************************
// baud selections and rates
// ****************************************************************
`define SCLH_BAUD_19200   2'd0
`define SCLH_BAUD_9600    2'd1
`define SCLH_BAUD_4800    2'd2
`define SCLH_BAUD_2400    2'd3
`define SCLH_CLK_HZ       200000000
`define SCLH_RATE_19200   19200
`define SCLH_RATE_9600    9600
`define SCLH_RATE_4800    4800
`define SCLH_RATE_2400    2400
`define SCLH_DATA_BITS    8
`define SCLH_STOP_BITS    1
// ****************************************************************
// character codes
// ****************************************************************
`define SCLH_CH_BS        8'h08
`define SCLH_CH_LF        8'h0a
`define SCLH_CH_CR        8'h0d
`define SCLH_CH_XON       8'h11
`define SCLH_CH_XOFF      8'h13
`define SCLH_CH_SP        8'h20
`define SCLH_CH_GT        8'h3e
`define SCLH_CTL_MAX      8'h1f
`define SCLH_LOOP_PAT     8'ha5
`endif

// ===== rtl/sclh_top.v
// serial command line handler: uart, line editing, echo/prompt/flow-control returns, loopback test
//
// Overview of operation
// - reset: 9600 8N1, echo on, flow off
// - rate 19200/9600/4800, and 2400 only where CLK_HZ / 2400 fits 16 bits (at 200 MHz it wraps to 17797), applies from the next bit period
// - CR or LF hands buffered line over
// - backspace removes last char, never terminators
// - other control codes 00-1F ignored
// - CR LF sent when line handed over
// - echo on: every received printable char sent back while no line waits, no loopback test runs, no DONE write in that cycle and the reply queue has room
// - backspace echoed as BS space BS
// - CR LF or LF CR: echo first only
// - prompt mode sends CR LF > when ready; flow mode sends XON instead
// - flow mode: terminator answered XOFF CR LF / XOFF
// - after XOFF, CR LF still sent with echo
// - loopback test passes only if looped externally
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "sclh_map.vh"
module sclh_top #(
    parameter DEPTH  = 64,
    parameter AW     = 6,
    parameter CLK_HZ = `SCLH_CLK_HZ
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        rx_pin,
    output reg         tx_pin,
    output reg         loop_pass,
    output reg         loop_done
);
    // ****************************************************************
    // baud divisors
    // ****************************************************************
    localparam integer DW_19200 = CLK_HZ / `SCLH_RATE_19200;
    localparam integer DW_9600  = CLK_HZ / `SCLH_RATE_9600;
    localparam integer DW_4800  = CLK_HZ / `SCLH_RATE_4800;
    localparam integer DW_2400  = CLK_HZ / `SCLH_RATE_2400;
    localparam [15:0] DIV_19200 = DW_19200[15:0];
    localparam [15:0] DIV_9600  = DW_9600[15:0];
    localparam [15:0] DIV_4800  = DW_4800[15:0];
    localparam [15:0] DIV_2400  = DW_2400[15:0];
    localparam [2:0]  RX_IDLE = 3'd0, RX_START = 3'd1, RX_DATA = 3'd2, RX_STOP = 3'd3;
    localparam [1:0]  TX_IDLE = 2'd0, TX_START = 2'd1, TX_DATA = 2'd2, TX_STOP = 2'd3;

    reg  [31:0]   ctrl;
    reg  [15:0]   bit_div;
    reg           rx_s1, rx_s2;
    wire          rx_line;
    reg  [2:0]    rx_state;
    reg  [15:0]   rx_cnt;
    reg  [2:0]    rx_bit;
    reg  [7:0]    rx_shift;
    reg           rx_valid;
    reg  [7:0]    rx_byte;
    reg  [1:0]    tx_state;
    reg  [15:0]   tx_cnt;
    reg  [2:0]    tx_bit;
    reg  [7:0]    tx_shift;
    reg  [7:0]    oq [0:7];
    reg  [2:0]    oq_wr, oq_rd;
    reg  [3:0]    oq_cnt;
    reg  [7:0]    line_mem [0:DEPTH-1];
    reg  [AW:0]   line_len;
    reg  [AW:0]   rd_ptr;
    reg           line_ready;
    reg           parse_busy;
    reg  [7:0]    last_term;
    reg           loop_wait;
    reg  [15:0]   loop_tmr;
    wire [15:0]   bit_last;
    wire          acc_wr, acc_rd, is_term, is_ctl;
    reg  [3:0]    push_n;
    reg  [31:0]   push_v;

    // baud choice applies to the very next bit period
    always @* begin
        case (ctrl[`SCLH_CTRL_BAUD_HI:`SCLH_CTRL_BAUD_LO])
            `SCLH_BAUD_19200: bit_div = DIV_19200;
            `SCLH_BAUD_4800:  bit_div = DIV_4800;
            `SCLH_BAUD_2400:  bit_div = DIV_2400;
            default:          bit_div = DIV_9600;
        endcase
    end
    // counters run to zero, so the reload is one less than the bit period
    assign bit_last = bit_div - 16'h1;

    // ****************************************************************
    // apb slave: zero wait states, unmapped reads return zero
    // ****************************************************************
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign acc_wr  = psel & penable & pwrite;
    assign acc_rd  = psel & penable & ~pwrite;

    always @* begin
        case (paddr)
            `SCLH_CTRL_OFS:  prdata = ctrl;
            `SCLH_STAT_OFS:  prdata = {26'h0, parse_busy, loop_wait, loop_done, loop_pass, line_ready, oq_cnt == 4'd0};
            `SCLH_LINE_OFS:  prdata = {{(31-AW){1'b0}}, line_len};
            `SCLH_LDATA_OFS: prdata = {24'h0, line_mem[rd_ptr[AW-1:0]]};
            default:         prdata = 32'h0;
        endcase
    end

    // ****************************************************************
    // receiver: two-flop sync, mid-bit sampling, 8N1
    // ****************************************************************
    assign rx_line = rx_s2;
    always @(posedge core_clk) begin
        rx_valid <= 1'b0;
        if (!rst_n) begin
            rx_s1 <= 1'b1; rx_s2 <= 1'b1;
            rx_state <= RX_IDLE; rx_cnt <= 16'h0; rx_bit <= 3'd0;
            rx_shift <= 8'h0; rx_byte <= 8'h0;
        end else begin
            rx_s1 <= rx_pin;
            rx_s2 <= rx_s1;
            case (rx_state)
                RX_IDLE: if (!rx_line) begin
                    rx_state <= RX_START;
                    rx_cnt   <= {1'b0, bit_div[15:1]};
                end
                RX_START: if (rx_cnt == 16'h0) begin
                    rx_cnt   <= bit_last;
                    rx_bit   <= 3'd0;
                    rx_state <= rx_line ? RX_IDLE : RX_DATA; // glitch rejects
                end else rx_cnt <= rx_cnt - 16'h1;
                RX_DATA: if (rx_cnt == 16'h0) begin
                    rx_cnt   <= bit_last;
                    rx_shift <= {rx_line, rx_shift[7:1]};
                    rx_bit   <= rx_bit + 3'd1;
                    if (rx_bit == 3'd7) rx_state <= RX_STOP;
                end else rx_cnt <= rx_cnt - 16'h1;
                RX_STOP: if (rx_cnt == 16'h0) begin
                    rx_state <= RX_IDLE;
                    if (rx_line) begin
                        rx_valid <= 1'b1;
                        rx_byte  <= rx_shift;
                    end
                end else rx_cnt <= rx_cnt - 16'h1;
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // reply sequence for each event; up to three bytes packed low first
    // ****************************************************************
    assign is_term = (rx_byte == `SCLH_CH_CR) || (rx_byte == `SCLH_CH_LF);
    assign is_ctl  = rx_byte <= `SCLH_CTL_MAX;
    wire echo_on   = ctrl[`SCLH_CTRL_ECHO];
    wire flow_on   = ctrl[`SCLH_CTRL_XON];
    wire prompt_on = ctrl[`SCLH_CTRL_PROMPT];
    // second of a CR/LF pair: already terminated, echo and parse nothing
    wire pair_2nd  = is_term && (last_term != 8'h00) && (last_term != rx_byte);
    wire done_wr   = acc_wr && (paddr == `SCLH_DONE_OFS);

    always @* begin
        push_n = 4'd0;
        push_v = 32'h0;
        if (done_wr && parse_busy) begin
            if (flow_on) begin
                push_n = 4'd1; push_v = {24'h0, `SCLH_CH_XON};
            end else if (prompt_on) begin
                push_n = 4'd3; push_v = {8'h0, `SCLH_CH_GT, `SCLH_CH_LF, `SCLH_CH_CR};
            end
        end else if (rx_valid && !loop_wait) begin
            if (is_term && !pair_2nd && !line_ready) begin
                if (flow_on && echo_on) begin
                    push_n = 4'd3; push_v = {8'h0, `SCLH_CH_LF, `SCLH_CH_CR, `SCLH_CH_XOFF};
                end else if (flow_on) begin
                    push_n = 4'd1; push_v = {24'h0, `SCLH_CH_XOFF};
                end else begin
                    push_n = 4'd2; push_v = {16'h0, `SCLH_CH_LF, `SCLH_CH_CR};
                end
            end else if (!is_term && echo_on && !line_ready) begin
                if (rx_byte == `SCLH_CH_BS) begin
                    push_n = 4'd3; push_v = {8'h0, `SCLH_CH_BS, `SCLH_CH_SP, `SCLH_CH_BS};
                end else if (!is_ctl) begin
                    push_n = 4'd1; push_v = {24'h0, rx_byte};
                end
            end
        end
    end

    // ****************************************************************
    // control, line buffer, reply queue, loopback test
    // ****************************************************************
    integer i;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl <= `SCLH_CTRL_RST;
            line_len <= {(AW+1){1'b0}}; rd_ptr <= {(AW+1){1'b0}};
            line_ready <= 1'b0; parse_busy <= 1'b0; last_term <= 8'h00;
            oq_wr <= 3'd0; oq_cnt <= 4'd0;
            loop_wait <= 1'b0; loop_pass <= 1'b0; loop_done <= 1'b0;
            loop_tmr <= 16'h0;
        end else begin
            // fail timer runs only once the pattern has fully left the line
            if (!loop_wait || tx_state != TX_IDLE || oq_cnt != 4'd0)
                loop_tmr <= 16'h0;
            else
                loop_tmr <= loop_tmr + 16'h1;
            if (acc_wr && paddr == `SCLH_CTRL_OFS)
                ctrl <= {26'h0, pwdata[5:0]};
            if (acc_rd && paddr == `SCLH_LDATA_OFS && rd_ptr < line_len)
                rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
            if (acc_wr && paddr == `SCLH_LPOP_OFS) begin
                line_ready <= 1'b0;                                             // parser took the line
                parse_busy <= 1'b1;
                line_len   <= {(AW+1){1'b0}};
                rd_ptr     <= {(AW+1){1'b0}};
            end
            if (done_wr) parse_busy <= 1'b0;
            // line editing; chars arriving while a line waits are dropped
            if (rx_valid && !loop_wait) begin
                // a completed pair clears the memory so the next line starts fresh
                last_term <= (is_term && !pair_2nd) ? rx_byte : 8'h00;
                if (is_term && !pair_2nd && !line_ready)
                    line_ready <= 1'b1;
                else if (rx_byte == `SCLH_CH_BS && line_len != 0 && !line_ready)
                    line_len <= line_len - {{AW{1'b0}}, 1'b1};
                else if (!is_ctl && !line_ready && line_len < DEPTH) begin
                    line_mem[line_len[AW-1:0]] <= rx_byte;
                    line_len <= line_len + {{AW{1'b0}}, 1'b1};
                end
            end
            // loopback: send pattern, pass only if it returns intact
            if (ctrl[`SCLH_CTRL_LOOPRUN] && !loop_wait && oq_cnt == 4'd0) begin
                loop_wait <= 1'b1; loop_done <= 1'b0; loop_pass <= 1'b0;
                ctrl[`SCLH_CTRL_LOOPRUN] <= 1'b0;
                oq[oq_wr] <= `SCLH_LOOP_PAT;
                oq_wr <= oq_wr + 3'd1;
            end else if (loop_wait && (rx_valid || loop_tmr == bit_div)) begin
                loop_wait <= 1'b0; loop_done <= 1'b1;
                loop_pass <= rx_valid && rx_byte == `SCLH_LOOP_PAT;
            end else if (push_n != 4'd0 && oq_cnt + push_n <= 4'd8) begin
                for (i = 0; i < 4; i = i + 1)
                    if (i < push_n) oq[oq_wr + i[2:0]] <= push_v[i*8 +: 8];
                oq_wr <= oq_wr + push_n[2:0];
            end
            oq_cnt <= oq_cnt + ((ctrl[`SCLH_CTRL_LOOPRUN] && !loop_wait && oq_cnt == 4'd0) ? 4'd1 :
                      (loop_wait ? 4'd0 : ((push_n != 4'd0 && oq_cnt + push_n <= 4'd8) ? push_n : 4'd0)))
                      - ((tx_state == TX_IDLE && oq_cnt != 4'd0) ? 4'd1 : 4'd0);
        end
    end

    // ****************************************************************
    // transmitter: 8N1 from reply queue
    // ****************************************************************
    always @(posedge core_clk) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE; tx_cnt <= 16'h0; tx_bit <= 3'd0;
            tx_shift <= 8'h0; tx_pin <= 1'b1; oq_rd <= 3'd0;
        end else begin
            case (tx_state)
                TX_IDLE: if (oq_cnt != 4'd0) begin
                    tx_shift <= oq[oq_rd];
                    oq_rd    <= oq_rd + 3'd1;
                    tx_pin   <= 1'b0;
                    tx_cnt   <= bit_last;
                    tx_state <= TX_START;
                end
                TX_START: if (tx_cnt == 16'h0) begin
                    tx_pin <= tx_shift[0]; tx_bit <= 3'd0;
                    tx_cnt <= bit_last; tx_state <= TX_DATA;
                end else tx_cnt <= tx_cnt - 16'h1;
                TX_DATA: if (tx_cnt == 16'h0) begin
                    tx_cnt <= bit_last;
                    tx_bit <= tx_bit + 3'd1;
                    if (tx_bit == 3'd7) begin
                        tx_pin <= 1'b1; tx_state <= TX_STOP;
                    end else begin
                        tx_pin <= tx_shift[tx_bit + 3'd1];
                    end
                end else tx_cnt <= tx_cnt - 16'h1;
                TX_STOP: if (tx_cnt == 16'h0) tx_state <= TX_IDLE;
                         else tx_cnt <= tx_cnt - 16'h1;
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
endmodule // sclh_top

// ===== verif/sclh_sva.sv
// assertion checker for the serial command line handler, bound to its top module
`timescale 1ns/1ps
`include "sclh_map.vh"
module sclh_sva #(
    parameter int MIN_BIT = 10416 // shortest bit time in clocks
) (
    input wire        core_clk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        tx_pin,
    input wire        loop_pass,
    input wire        loop_done
);
    reg [31:0] low_cnt;
    reg [4:0]  ctrl_sh;
    wire       rd = psel && penable && !pwrite;
    // shadow of writable control bits; bit 5 self-clears so it is left out
    always @(posedge core_clk) begin
        if (!rst_n) begin
            low_cnt <= 32'h0;
            ctrl_sh <= 5'h05;
        end else begin
            low_cnt <= tx_pin ? 32'h0 : low_cnt + 32'h1;
            if (psel && penable && pwrite && pready && paddr == `SCLH_CTRL_OFS)
                ctrl_sh <= pwdata[4:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    a_zero_wait: assert property (s_setup ##1 s_access |-> pready) else $error("access not ready");
    a_no_slverr: assert property (s_access |-> !pslverr) else $error("slave error raised");
    a_reset_idle: assert property ($rose(rst_n) |-> tx_pin && !loop_pass && !loop_done)
        else $error("outputs not idle after reset");
    a_ctrl_back: assert property (rd && paddr == `SCLH_CTRL_OFS |-> prdata[4:0] == ctrl_sh)
        else $error("control readback wrong");
    a_unmapped_zero: assert property (rd && paddr > `SCLH_DONE_OFS |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_loop_pair: assert property (loop_pass |-> loop_done) else $error("pass without done");
    a_stat_loop: assert property (rd && paddr == `SCLH_STAT_OFS |-> prdata[3:2] == {loop_done, loop_pass})
        else $error("status loop bits wrong");
    a_tx_bit_min: assert property ($rose(tx_pin) |-> low_cnt >= MIN_BIT)
        else $error("tx low run too short");
endmodule // sclh_sva
bind sclh_top sclh_sva #(.MIN_BIT(DIV_19200)) i_sclh_sva (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_pin(tx_pin), .loop_pass(loop_pass), .loop_done(loop_done));

// ===== verif/sclh_host.sv
// host terminal model: 8N1 sender and receiver with XON/XOFF pacing
`timescale 1ns/1ps
`include "sclh_map.vh"
module sclh_host #(
    parameter int BIT = 10416
) (
    input  wire       core_clk,
    input  wire       tx_pin,
    input  wire       flow,
    output reg        rx_pin,
    output reg        got,
    output reg  [7:0] got_data
);
    reg       xon_ok;
    reg [7:0] sh;
    integer   j;
    initial begin
        rx_pin = 1'b1; // line idles at mark level
        got = 1'b0;
        got_data = 8'h00;
        xon_ok = 1'b0;
    end
    // one frame lsb first; in paced mode hold off until XON has been seen
    task send(input [7:0] b);
        reg [9:0] fr;
        integer   i;
        begin
            fr = {1'b1, b, 1'b0};
            while (flow && !xon_ok) @(posedge core_clk);
            for (i = 0; i < 10; i = i + 1) begin
                rx_pin <= fr[i];
                repeat (BIT) @(posedge core_clk);
            end
        end
    endtask
    // receiver samples mid bit, so slight rate error is tolerated
    always begin
        @(negedge tx_pin);
        repeat (BIT / 2) @(posedge core_clk);
        for (j = 0; j < 8; j = j + 1) begin
            repeat (BIT) @(posedge core_clk);
            sh[j] = tx_pin;
        end
        repeat (BIT) @(posedge core_clk);
        got_data <= sh;
        got <= 1'b1;
        if (sh == `SCLH_CH_XON) xon_ok = 1'b1;
        else if (sh == `SCLH_CH_XOFF) xon_ok = 1'b0;
        @(posedge core_clk);
        got <= 1'b0;
    end
endmodule // sclh_host

// ===== verif/sclh_top_tb.sv
// self-checking testbench of the serial command line handler
`timescale 1ns/1ps
`include "sclh_map.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module sclh_top_tb;
    localparam int BIT = 10; // cycles per bit at 19200 baud with the scaled-down clock figure below
    reg          core_clk, rst_n, psel, penable, pwrite, loop_on, flow_on;
    reg  [11:0]  paddr;
    reg  [31:0]  pwdata;
    wire [31:0]  prdata;
    wire         pready, pslverr, tx_pin, loop_pass, loop_done, host_rx, got;
    wire [7:0]   got_data;
    int          fail_count, checks, k;
    integer      seed;
    reg  [7:0]   ch_q[$];
    reg  [63:0]  rd_q[$];
    reg  [63:0]  e;
    reg  [7:0]   c;
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // a small clock figure keeps each frame short enough for a brief run
    sclh_top #(.CLK_HZ(192000)) i_sclh_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_pin(loop_on ? tx_pin : host_rx), .tx_pin(tx_pin), .loop_pass(loop_pass), .loop_done(loop_done));
    sclh_host #(.BIT(BIT)) host (.core_clk(core_clk), .tx_pin(tx_pin), .flow(flow_on), .rx_pin(host_rx),
        .got(got), .got_data(got_data));
    task close_out;
        begin
            $display("checks %0d mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // apb transfer; reads note the masked expectation for the watcher
    task apb(input w, input [11:0] a, input [31:0] d, input [31:0] m);
        begin
            @(posedge core_clk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            if (!w) rd_q.push_back({m, d & m});
            @(posedge core_clk);
            penable <= 1'b1;
            do @(posedge core_clk); while (pready !== 1'b1);
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask
    task drain;
        while (ch_q.size() != 0) @(posedge core_clk);
    endtask
    // watcher: each completed read and each returned byte meets the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) begin
            e = rd_q.pop_front();
            `CHK("prdata", e[31:0], prdata & e[63:32])
        end
        if (got) `CHK("tx byte", (ch_q.size() != 0 ? ch_q.pop_front() : 8'hxx), got_data)
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("Error watchdog expected done seen timeout");
        close_out;
    end
    initial begin
        seed = 32'ha9fd;
        {rst_n, psel, penable, pwrite, loop_on, flow_on} = 6'h0;
        paddr = 12'h0; pwdata = 32'h0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(0, `SCLH_CTRL_OFS, `SCLH_CTRL_RST, 32'h3f);
        apb(1, 12'h018, 32'hffff_ffff, 32'h0);
        apb(0, 12'h018, 32'h0, 32'hffff_ffff);
        apb(1, `SCLH_CTRL_OFS, 32'h4, 32'h0);
        apb(0, `SCLH_CTRL_OFS, 32'h4, 32'h3f);
        $display("test registers done");
        c = 8'h21 + 8'($unsigned($random(seed)) % 94);
        ch_q.push_back(c); host.send(c);
        host.send(8'h01);
        ch_q.push_back(`SCLH_CH_BS); ch_q.push_back(`SCLH_CH_SP); ch_q.push_back(`SCLH_CH_BS);
        host.send(`SCLH_CH_BS);
        ch_q.push_back(c); host.send(c);
        ch_q.push_back(`SCLH_CH_CR); ch_q.push_back(`SCLH_CH_LF);
        host.send(`SCLH_CH_CR); host.send(`SCLH_CH_LF);
        drain;
        apb(0, `SCLH_STAT_OFS, 32'h2, 32'h2);
        apb(0, `SCLH_LINE_OFS, 32'h1, 32'hffff_ffff);
        apb(0, `SCLH_LDATA_OFS, {24'h0, c}, 32'hff);
        $display("test line editing done");
        apb(1, `SCLH_CTRL_OFS, 32'h14, 32'h0);
        flow_on <= 1'b1;
        apb(1, `SCLH_LPOP_OFS, 32'h0, 32'h0);
        ch_q.push_back(`SCLH_CH_XON);
        apb(1, `SCLH_DONE_OFS, 32'h0, 32'h0);
        ch_q.push_back(`SCLH_CH_XOFF); ch_q.push_back(`SCLH_CH_CR); ch_q.push_back(`SCLH_CH_LF);
        host.send(`SCLH_CH_CR);
        drain;
        $display("test flow control done");
        flow_on <= 1'b0;
        apb(1, `SCLH_CTRL_OFS, 32'h0c, 32'h0);
        host.send(c); // line still waiting: dropped without echo
        apb(1, `SCLH_LPOP_OFS, 32'h0, 32'h0);
        ch_q.push_back(`SCLH_CH_CR); ch_q.push_back(`SCLH_CH_LF); ch_q.push_back(`SCLH_CH_GT);
        apb(1, `SCLH_DONE_OFS, 32'h0, 32'h0);
        drain;
        ch_q.push_back(c); host.send(c);
        drain;
        $display("test prompt done");
        // looped back first so a stale pass flag cannot hide the unlooped failure
        for (k = 1; k >= 0; k--) begin
            loop_on <= k[0];
            ch_q.push_back(`SCLH_LOOP_PAT);
            apb(1, `SCLH_CTRL_OFS, 32'h20, 32'h0);
            drain;
            repeat (3 * BIT) @(posedge core_clk);
            `CHK("loop result", {1'b1, k[0]}, {loop_done, loop_pass})
        end
        $display("test loopback done");
        close_out;
    end
endmodule // sclh_top_tb
